// ===== src/gps_nav_serial_link.sv
// navigation input, format detection, fuel output and diagnostic indications
`timescale 1ns/100ps
// Summary of operation
// - incoming characters are one start bit, eight data bits, no parity.
// - input runs at 4800 for marine, 9600 for aviation and 1200 for binary format.
// - format and rate are found automatically, independent of the fuel output code.
// - aviation sentences open with an identifier letter and end in CR LF or CR alone.
// - fuel data leaves as one start, eight data, no parity at a fixed 9600 baud.
// - the fuel output code selects the format, with 0 silent and 5 unused.
// - marine or binary input suppresses fuel output whatever the code.
// - with no characters at all the three navigation parameters leave the scan.
// - while detection runs the no-communication message shows and the parameters go.
// - a no-signal report shows its message and drops all three parameters.
// - a no-waypoint report drops required fuel and reserve but keeps mileage.
// - flow shows zeros when low, flashes the flow tag when lost, dashes when absent.
module gps_nav_serial_link #(
  parameter int unsigned CLK_HZ      = nav_link_pkg::CLK_HZ,
  parameter int unsigned SILENCE_CYC = nav_link_pkg::SILENCE_CYC,
  parameter int unsigned FLASH_CYC   = 25_000_000
) (
  input  wire logic                        sys_clk_in,
  input  wire logic                        reset_in,
  input  wire logic                        nav_rx_in,
  input  wire logic [3:0]                  fuel_output_format_code_in,
  input  wire logic                        nav_no_signal_in,
  input  wire logic                        nav_no_waypoint_in,
  input  wire logic                        flow_low_in,
  input  wire logic                        flow_lost_in,
  input  wire logic                        flow_absent_in,
  input  wire logic [7:0]                  fuel_tx_data_in,
  input  wire logic                        fuel_tx_valid_in,
  output logic                             fuel_tx_ready_out,
  output logic                             fuel_tx_out,
  output logic [7:0]                       nav_data_out,
  output logic                             nav_valid_out,
  output nav_link_pkg::nav_fmt_e           nav_format_out,
  output nav_link_pkg::link_state_e        link_state_out,
  output nav_link_pkg::nav_display_s       nav_display_out,
  output nav_link_pkg::flow_display_s      flow_display_out
);
  localparam int unsigned DW = nav_link_pkg::DIV_W;
  // bit divisors follow the system clock rate
  localparam int unsigned DIV_MARINE   = CLK_HZ / nav_link_pkg::BAUD_MARINE;
  localparam int unsigned DIV_AVIATION = CLK_HZ / nav_link_pkg::BAUD_AVIATION;
  localparam int unsigned DIV_BINARY   = CLK_HZ / nav_link_pkg::BAUD_BINARY;
  localparam int unsigned DIV_FUEL_TX  = CLK_HZ / nav_link_pkg::BAUD_FUEL_TX;

  logic rx_s1_r;
  logic rx_s2_r;
  always_ff @(posedge sys_clk_in)
  begin
    if (reset_in)
    begin
      rx_s1_r <= 1'b1;
      rx_s2_r <= 1'b1;
    end
    else
    begin
      rx_s1_r <= nav_rx_in;
      rx_s2_r <= rx_s1_r;
    end
  end

  // rate hunt cycles through the three candidate rates
  logic [1:0] hunt_r;
  nav_link_pkg::nav_fmt_e    fmt_r;
  nav_link_pkg::link_state_e state_r;
  logic [DW-1:0] rx_div;
  // rate tied to the format under trial
  assign rx_div = (hunt_r == 2'd0) ? DW'(DIV_MARINE) :
                  (hunt_r == 2'd1) ? DW'(DIV_AVIATION) :
                                     DW'(DIV_BINARY);

  logic [7:0] rx_data;
  logic       rx_valid;
  logic       rx_err;
  serial_rx_frame #(.DIV_W(DW)) u_rx (
    .sys_clk_in    (sys_clk_in),
    .reset_in      (reset_in),
    .line_in       (rx_s2_r),
    .bit_div_in    (rx_div),
    .data_out      (rx_data),
    .valid_out     (rx_valid),
    .frame_err_out (rx_err)
  );

  // character classes used for detection
  wire is_dollar  = (rx_data == nav_link_pkg::CH_DOLLAR);
  wire is_cr      = (rx_data == nav_link_pkg::CH_CR);
  wire is_lf      = (rx_data == nav_link_pkg::CH_LF);
  wire is_print   = (rx_data >= 8'h20) && (rx_data < 8'h7f);
  wire is_ascii   = is_print || is_cr || is_lf;
  // identifier letters A B C D E I L
  wire is_av_id   = (rx_data >= 8'h41 && rx_data <= 8'h45) ||
                    (rx_data == 8'h49) || (rx_data == 8'h4c);
  logic after_cr_r;
  // CR alone or CR LF both terminate; an identifier letter after either starts a sentence
  wire good_char  = (hunt_r == 2'd0) ? (is_ascii && (!after_cr_r || is_dollar || is_lf)) :
                    (hunt_r == 2'd1) ? (is_ascii && (!after_cr_r || is_av_id || is_lf)) :
                                       1'b1;
  wire hit_char   = (hunt_r == 2'd0) ? is_dollar :
                    (hunt_r == 2'd1) ? (after_cr_r && is_av_id) :
                                       rx_valid;
  wire bad_char   = rx_err || (rx_valid && !good_char);

  logic [4:0]  bad_r;
  logic [2:0]  hit_r;
  logic [31:0] quiet_r;
  wire silent     = (quiet_r >= SILENCE_CYC);
  wire bad_limit  = (bad_r == 5'(nav_link_pkg::BAD_LIMIT - 1)) && bad_char;
  wire locked_now = (hit_r == 3'(nav_link_pkg::HIT_LIMIT - 1)) && rx_valid && hit_char;
  nav_link_pkg::nav_fmt_e hunt_fmt;
  assign hunt_fmt = (hunt_r == 2'd0) ? nav_link_pkg::NAV_MARINE :
                    (hunt_r == 2'd1) ? nav_link_pkg::NAV_AVIATION :
                                       nav_link_pkg::NAV_BINARY;

  // detection runs from received traffic only
  always_ff @(posedge sys_clk_in)
  begin
    if (reset_in)
    begin
      state_r    <= nav_link_pkg::LINK_SILENT;
      fmt_r      <= nav_link_pkg::NAV_NONE;
      hunt_r     <= 2'd0;
      bad_r      <= 5'h00;
      hit_r      <= 3'h0;
      quiet_r    <= 32'h0000_0000;
      after_cr_r <= 1'b0;
    end
    else
    begin
      quiet_r <= (rx_valid || rx_err) ? 32'h0000_0000 :
                 (silent ? quiet_r : quiet_r + 32'h1);
      if (rx_valid)
        after_cr_r <= is_cr || (after_cr_r && is_lf);
      if (bad_char)
        bad_r <= bad_r + 5'h01;
      else if (rx_valid && hit_char)
        bad_r <= 5'h00;
      unique case (state_r)
        nav_link_pkg::LINK_SILENT:
          if (rx_valid || rx_err)
            state_r <= nav_link_pkg::LINK_DETECTING;
        nav_link_pkg::LINK_DETECTING:
          if (silent)
            state_r <= nav_link_pkg::LINK_SILENT;
          else if (bad_limit)
          begin
            hunt_r <= (hunt_r == 2'd2) ? 2'd0 : hunt_r + 2'd1;
            bad_r  <= 5'h00;
            hit_r  <= 3'h0;
          end
          else if (locked_now)
          begin
            state_r <= nav_link_pkg::LINK_LOCKED;
            fmt_r   <= hunt_fmt;
          end
          else if (rx_valid && hit_char)
            hit_r <= hit_r + 3'h1;
        nav_link_pkg::LINK_LOCKED:
          if (silent || bad_limit)
            state_r <= nav_link_pkg::LINK_RESTART;
        nav_link_pkg::LINK_RESTART:
        begin
          state_r <= silent ? nav_link_pkg::LINK_SILENT : nav_link_pkg::LINK_DETECTING;
          fmt_r   <= nav_link_pkg::NAV_NONE;
          bad_r   <= 5'h00;
          hit_r   <= 3'h0;
        end
        default:
          state_r <= nav_link_pkg::LINK_SILENT;
      endcase
    end
  end

  // fuel output gating
  wire code_valid = (fuel_output_format_code_in != nav_link_pkg::FMT_OFF) &&
                    (fuel_output_format_code_in != nav_link_pkg::FMT_UNUSED) &&
                    (fuel_output_format_code_in <= nav_link_pkg::FMT_MAX);
  // marine or binary input suppresses output
  wire fmt_block  = (fmt_r == nav_link_pkg::NAV_MARINE) || (fmt_r == nav_link_pkg::NAV_BINARY);
  // code 0 and 5 send nothing
  wire tx_enable  = code_valid && !fmt_block;

  // fixed rate transmitter, 10 bit frame
  logic [9:0]    tx_shift_r;
  logic [3:0]    tx_bits_r;
  logic [DW-1:0] tx_cnt_r;
  logic          tx_line_r;
  wire tx_idle = (tx_bits_r == 4'h0);
  assign fuel_tx_ready_out = tx_idle && tx_enable;
  always_ff @(posedge sys_clk_in)
  begin
    if (reset_in)
    begin
      tx_shift_r <= 10'h3ff;
      tx_bits_r  <= 4'h0;
      tx_cnt_r   <= '0;
      tx_line_r  <= 1'b1;
    end
    else if (tx_idle)
    begin
      tx_line_r <= 1'b1;
      if (fuel_tx_valid_in && tx_enable)
      begin
        tx_shift_r <= {1'b1, fuel_tx_data_in, 1'b0};
        // one count more keeps the stop bit a full period before the next byte
        tx_bits_r  <= 4'd11;
        tx_cnt_r   <= '0;
      end
    end
    else if (tx_cnt_r == '0)
    begin
      tx_line_r  <= tx_shift_r[0];
      tx_shift_r <= {1'b1, tx_shift_r[9:1]};
      tx_bits_r  <= tx_bits_r - 4'h1;
      tx_cnt_r   <= DW'(DIV_FUEL_TX - 1);
    end
    else
      tx_cnt_r <= tx_cnt_r - 1'b1;
  end
  assign fuel_tx_out = tx_line_r;

  // diagnostic indications
  logic [31:0] flash_cnt_r;
  logic        flash_r;
  nav_link_pkg::nav_display_s  nav_disp_r;
  nav_link_pkg::flow_display_s flow_disp_r;
  wire locked = (state_r == nav_link_pkg::LINK_LOCKED);
  wire detect = (state_r == nav_link_pkg::LINK_DETECTING) ||
                (state_r == nav_link_pkg::LINK_RESTART);
  wire no_sig = locked && nav_no_signal_in;
  wire no_waypoint_message = locked && !nav_no_signal_in && nav_no_waypoint_in;
  nav_link_pkg::nav_display_s  nav_disp_nxt;
  nav_link_pkg::flow_display_s flow_disp_nxt;
  // silence drops all three with no message
  assign nav_disp_nxt = '{no_comm_msg:        detect,
                          no_signal_msg:      no_sig,
                          no_waypoint_msg:    no_waypoint_message,
                          show_required_fuel: locked && !no_sig && !no_waypoint_message,
                          show_reserve:       locked && !no_sig && !no_waypoint_message,
                          show_mileage:       locked && !no_sig};
  assign flow_disp_nxt = '{flow_zero:      flow_low_in || flow_lost_in,
                           flow_tag_flash: flow_lost_in && flash_r,
                           time_dashes:    flow_absent_in};
  always_ff @(posedge sys_clk_in)
  begin
    if (reset_in)
    begin
      flash_cnt_r <= 32'h0000_0000;
      flash_r     <= 1'b0;
      nav_disp_r  <= '0;
      flow_disp_r <= '0;
    end
    else
    begin
      flash_cnt_r <= (flash_cnt_r >= FLASH_CYC - 1) ? 32'h0000_0000 : flash_cnt_r + 32'h1;
      if (flash_cnt_r >= FLASH_CYC - 1)
        flash_r <= !flash_r;
      nav_disp_r  <= nav_disp_nxt;
      flow_disp_r <= flow_disp_nxt;
    end
  end

  assign nav_display_out  = nav_disp_r;
  assign flow_display_out = flow_disp_r;
  assign nav_data_out     = rx_data;
  assign nav_valid_out    = rx_valid && locked;
  assign nav_format_out   = fmt_r;
  assign link_state_out   = state_r;
endmodule

// ===== src/nav_link_pkg.sv
// shared constants and types for the navigation serial link
package nav_link_pkg;
  localparam int unsigned CLK_HZ        = 100_000_000;
  localparam int unsigned BAUD_MARINE   = 4_800;
  localparam int unsigned BAUD_AVIATION = 9_600;
  localparam int unsigned BAUD_BINARY   = 1_200;
  localparam int unsigned BAUD_FUEL_TX  = 9_600;
  localparam int unsigned DIV_MARINE    = CLK_HZ / BAUD_MARINE;
  localparam int unsigned DIV_AVIATION  = CLK_HZ / BAUD_AVIATION;
  localparam int unsigned DIV_BINARY    = CLK_HZ / BAUD_BINARY;
  localparam int unsigned DIV_FUEL_TX   = CLK_HZ / BAUD_FUEL_TX;
  localparam int unsigned DIV_W         = 17;
  localparam int unsigned DATA_BITS     = 8;
  // silence time in ms before the link counts as absent
  localparam int unsigned SILENCE_MS    = 2_000;
  localparam int unsigned SILENCE_CYC   = SILENCE_MS * (CLK_HZ / 1000);
  // bad-character tally that forces detection to restart
  localparam int unsigned BAD_LIMIT     = 16;
  // characters of a format that confirm detection
  localparam int unsigned HIT_LIMIT     = 4;
  localparam logic [7:0] CH_CR     = 8'h0d;
  localparam logic [7:0] CH_LF     = 8'h0a;
  localparam logic [7:0] CH_DOLLAR = 8'h24;
  localparam logic [3:0] FMT_OFF   = 4'h0;
  localparam logic [3:0] FMT_UNUSED = 4'h5;
  localparam logic [3:0] FMT_MAX   = 4'h8;

  typedef enum logic [3:0] {
    NAV_NONE     = 4'b0001,
    NAV_MARINE   = 4'b0010,
    NAV_AVIATION = 4'b0100,
    NAV_BINARY   = 4'b1000
  } nav_fmt_e;

  typedef enum logic [3:0] {
    LINK_SILENT    = 4'b0001,
    LINK_DETECTING = 4'b0010,
    LINK_LOCKED    = 4'b0100,
    LINK_RESTART   = 4'b1000
  } link_state_e;

  typedef struct packed {
    logic no_comm_msg;
    logic no_signal_msg;
    logic no_waypoint_msg;
    logic show_required_fuel;
    logic show_reserve;
    logic show_mileage;
  } nav_display_s;

  typedef struct packed {
    logic flow_zero;
    logic flow_tag_flash;
    logic time_dashes;
  } flow_display_s;
endpackage

// ===== src/serial_rx_frame.sv
// one-start eight-data no-parity character receiver with selectable divisor
`timescale 1ns/100ps
module serial_rx_frame #(
  parameter int unsigned DIV_W = 17
) (
  input  wire logic             sys_clk_in,
  input  wire logic             reset_in,
  input  wire logic             line_in,
  input  wire logic [DIV_W-1:0] bit_div_in,
  output logic      [7:0]       data_out,
  output logic                  valid_out,
  output logic                  frame_err_out
);
  typedef enum logic [3:0] {
    RX_IDLE  = 4'b0001,
    RX_START = 4'b0010,
    RX_DATA  = 4'b0100,
    RX_STOP  = 4'b1000
  } rx_state_e;

  rx_state_e        state_r;
  logic [DIV_W-1:0] cnt_r;
  logic [2:0]       bit_r;
  logic [7:0]       shift_r;
  logic             valid_r;
  logic             err_r;

  wire [DIV_W-1:0] half_div = bit_div_in >> 1;
  wire             cnt_done = (cnt_r == '0);

  always_ff @(posedge sys_clk_in)
  begin
    if (reset_in)
    begin
      state_r <= RX_IDLE;
      cnt_r   <= '0;
      bit_r   <= 3'h0;
      shift_r <= 8'h00;
      valid_r <= 1'b0;
      err_r   <= 1'b0;
    end
    else
    begin
      valid_r <= 1'b0;
      err_r   <= 1'b0;
      if (!cnt_done)
        cnt_r <= cnt_r - 1'b1;
      unique case (state_r)
        RX_IDLE:
          if (!line_in)
          begin
            state_r <= RX_START;
            cnt_r   <= half_div;
          end
        RX_START:
          if (cnt_done)
          begin
            state_r <= line_in ? RX_IDLE : RX_DATA;
            cnt_r   <= bit_div_in;
            bit_r   <= 3'h0;
          end
        RX_DATA:
          if (cnt_done)
          begin
            shift_r <= {line_in, shift_r[7:1]};
            cnt_r   <= bit_div_in;
            bit_r   <= bit_r + 3'h1;
            if (bit_r == 3'h7)
              state_r <= RX_STOP;
          end
        // stop bit low discards the character
        RX_STOP:
          if (cnt_done)
          begin
            state_r <= RX_IDLE;
            valid_r <= line_in;
            err_r   <= !line_in;
          end
      endcase
    end
  end

  assign data_out      = shift_r;
  assign valid_out     = valid_r;
  assign frame_err_out = err_r;
endmodule

// ===== bench/gps_nav_serial_link_props.sv
// concurrent checks on the navigation link ports
`timescale 1ns/100ps
module gps_nav_serial_link_props (
  input wire logic                         sys_clk_in,
  input wire logic                         reset_in,
  input wire logic [3:0]                   fuel_output_format_code_in,
  input wire logic                         nav_no_signal_in,
  input wire logic                         nav_no_waypoint_in,
  input wire logic                         flow_absent_in,
  input wire logic                         fuel_tx_valid_in,
  input wire logic                         fuel_tx_ready_out,
  input wire logic                         fuel_tx_out,
  input wire nav_link_pkg::nav_fmt_e       nav_format_out,
  input wire nav_link_pkg::link_state_e    link_state_out,
  input wire nav_link_pkg::nav_display_s   nav_display_out,
  input wire nav_link_pkg::flow_display_s  flow_display_out
);
  logic       locked;
  logic [2:0] shown;
  assign locked = (link_state_out == nav_link_pkg::LINK_LOCKED);
  // required fuel, reserve, mileage
  assign shown = nav_display_out[2:0];
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (reset_in);
  sequence s_take; fuel_tx_valid_in && fuel_tx_ready_out; endsequence
  sequence s_start_bit; ##[1:2] !fuel_tx_out [*8]; endsequence
  property p_tx_start; s_take |-> s_start_bit; endproperty
  a_tx_start: assert property (p_tx_start) else $error("fuel start bit missing");
  property p_tx_busy; s_take |=> !fuel_tx_ready_out; endproperty
  a_tx_busy: assert property (p_tx_busy) else $error("fuel ready while busy");
  property p_code_off;
    (fuel_output_format_code_in == nav_link_pkg::FMT_OFF ||
     fuel_output_format_code_in == nav_link_pkg::FMT_UNUSED ||
     fuel_output_format_code_in > nav_link_pkg::FMT_MAX) |-> !fuel_tx_ready_out;
  endproperty
  a_code_off: assert property (p_code_off) else $error("fuel output on idle code");
  property p_suppress;
    (nav_format_out == nav_link_pkg::NAV_MARINE || nav_format_out == nav_link_pkg::NAV_BINARY)
      |-> !fuel_tx_ready_out;
  endproperty
  a_suppress: assert property (p_suppress) else $error("fuel output not suppressed");
  property p_silent; link_state_out == nav_link_pkg::LINK_SILENT |=> shown == 3'h0; endproperty
  a_silent: assert property (p_silent) else $error("parameters shown while silent");
  property p_detect;
    link_state_out == nav_link_pkg::LINK_DETECTING |=> nav_display_out.no_comm_msg && shown == 3'h0;
  endproperty
  a_detect: assert property (p_detect) else $error("detection display wrong");
  property p_nosig; locked && nav_no_signal_in |=> nav_display_out.no_signal_msg && shown == 3'h0;
  endproperty
  a_nosig: assert property (p_nosig) else $error("no-signal display wrong");
  property p_nowpt;
    locked && !nav_no_signal_in && nav_no_waypoint_in |=> nav_display_out.no_waypoint_msg &&
      shown == 3'h1;
  endproperty
  a_nowpt: assert property (p_nowpt) else $error("no-waypoint display wrong");
  property p_dash; flow_absent_in |=> flow_display_out.time_dashes; endproperty
  a_dash: assert property (p_dash) else $error("time dashes missing");
  property p_drop;
    !$past(reset_in) && $past(link_state_out) == nav_link_pkg::LINK_LOCKED && !locked
      |-> link_state_out == nav_link_pkg::LINK_RESTART;
  endproperty
  a_drop: assert property (p_drop) else $error("lock left without restart");
endmodule
bind gps_nav_serial_link gps_nav_serial_link_props gps_nav_serial_link_props_i (.*);

// ===== bench/gps_nav_model.sv
// far-side receiver model: sends navigation characters, decodes fuel data
`timescale 1ns/100ps
module gps_nav_model #(
  parameter int unsigned FUEL_DIV = nav_link_pkg::DIV_FUEL_TX
) (
  input  wire logic sys_clk_in,
  input  wire logic fuel_line_in,
  output logic      nav_line_out
);
  initial nav_line_out = 1'b1;
  // start, eight data lsb first, high stop, at the format rate
  task automatic send_char(input int unsigned div, input logic [7:0] ch);
    logic [9:0] f;
    f = {1'b1, ch, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      @(posedge sys_clk_in);
      #1 nav_line_out = f[i];
      repeat (div - 1) @(posedge sys_clk_in);
    end
  endtask
  // sample each fuel bit at its centre, stop bit must be high
  task automatic get_fuel(output logic [7:0] d, output logic ok);
    int n;
    n = 0;
    ok = 1'b0;
    d = 8'h00;
    while (fuel_line_in && n < 3000)
    begin
      @(posedge sys_clk_in);
      n++;
    end
    if (n < 3000)
    begin
      repeat (FUEL_DIV / 2) @(posedge sys_clk_in);
      ok = !fuel_line_in;
      for (int i = 0; i < 9; i++)
      begin
        repeat (FUEL_DIV) @(posedge sys_clk_in);
        if (i < 8)
          d[i] = fuel_line_in;
        else
          ok = ok && fuel_line_in;
      end
    end
  endtask
endmodule

// ===== bench/test_gps_nav_serial_link.sv
// self-checking bench for the navigation serial link
`timescale 1ns/100ps
module test_gps_nav_serial_link;
  logic                         clk, rst, rx, nsig, nwpt, f_low, f_lost, f_abs, ok, fl0;
  logic                         tx_valid, tx_ready, tx_line, nav_valid;
  logic [3:0]                   code;
  logic [7:0]                   tx_data, nav_data, got;
  nav_link_pkg::nav_fmt_e       fmt;
  nav_link_pkg::link_state_e    st;
  nav_link_pkg::nav_display_s   disp;
  nav_link_pkg::flow_display_s  flow;
  int                           n_fail, cmp_count, n;
  // code, flow low, flow absent | ready, flow zero, time dashes
  logic [8:0]                   rows [11] = '{9'h000, 9'h036, 9'h04d, 9'h064, 9'h084,
                                              9'h0a0, 9'h0c4, 9'h0e4, 9'h104, 9'h120, 9'h1fb};
  // marine stream: sentence openings with the dollar that marks each one
  logic [7:0]                   nmea [8] = '{8'h52, 8'h4d, 8'h42, 8'h24,
                                             8'h52, 8'h4d, 8'h43, 8'h24};
  // slow clock figure so a marine character spans 1250 cycles
  localparam int unsigned       SIM_HZ = 600_000;
  localparam int unsigned       DIV_M  = SIM_HZ / nav_link_pkg::BAUD_MARINE;
  localparam int unsigned       DIV_F  = SIM_HZ / nav_link_pkg::BAUD_FUEL_TX;
  gps_nav_serial_link #(.CLK_HZ(SIM_HZ), .SILENCE_CYC(6000), .FLASH_CYC(8))
    gps_nav_serial_link_i (
    .sys_clk_in(clk), .reset_in(rst), .nav_rx_in(rx), .fuel_output_format_code_in(code),
    .nav_no_signal_in(nsig), .nav_no_waypoint_in(nwpt), .flow_low_in(f_low),
    .flow_lost_in(f_lost), .flow_absent_in(f_abs), .fuel_tx_data_in(tx_data),
    .fuel_tx_valid_in(tx_valid), .fuel_tx_ready_out(tx_ready), .fuel_tx_out(tx_line),
    .nav_data_out(nav_data), .nav_valid_out(nav_valid), .nav_format_out(fmt),
    .link_state_out(st), .nav_display_out(disp), .flow_display_out(flow));
  gps_nav_model #(.FUEL_DIV(DIV_F)) gps_nav_model_i (.sys_clk_in(clk), .fuel_line_in(tx_line),
    .nav_line_out(rx));
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    cmp_count++;
    if (g !== e)
    begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic complete_run();
    if (n_fail == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // a wait that used up its bound ends the run as failed
  task automatic expire(input int k, input int lim);
    if (k >= lim)
    begin
      n_fail++;
      complete_run();
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  // bounded wait while the link stays in one state
  task automatic wait_leave(input nav_link_pkg::link_state_e s);
    n = 0;
    while (st === s && n < 60000)
    begin
      tick(1);
      n++;
    end
    expire(n, 60000);
  endtask
  initial
  begin
    {n_fail, cmp_count} = '0;
    {rst, nsig, nwpt, f_low, f_lost, f_abs, tx_valid} = 7'h40;
    {code, tx_data} = 12'h000;
    tick(10);
    rst = 1'b0;
    tick(2);
    chk(8'(st), 8'(nav_link_pkg::LINK_SILENT));
    chk(8'(disp), 8'h00);
    chk({7'h0, tx_line}, 8'h01);
    for (int i = 0; i < 11; i++)
    begin
      {code, f_low, f_abs} = rows[i][8:3];
      tick(2);
      chk({7'h0, tx_ready}, {7'h0, rows[i][2]});
      chk({6'h0, flow.flow_zero, flow.time_dashes}, {6'h0, rows[i][1:0]});
    end
    {f_low, f_abs, f_lost} = 3'h1;
    tick(3);
    fl0 = flow.flow_tag_flash;
    tick(8);
    chk({7'h0, flow.flow_tag_flash}, {7'h0, ~fl0});
    f_lost = 1'b0;
    code = 4'h1;
    tx_data = 8'ha5;
    tick(2);
    fork
      begin
        tx_valid = 1'b1;
        n = 0;
        while (!tx_ready && n < 100)
        begin
          tick(1);
          n++;
        end
        expire(n, 100);
        tick(1);
        tx_valid = 1'b0;
      end
      gps_nav_model_i.get_fuel(got, ok);
    join
    chk(got, 8'ha5);
    chk({7'h0, ok}, 8'h01);
    gps_nav_model_i.send_char(DIV_M, nav_link_pkg::CH_DOLLAR);
    tick(50);
    chk(8'(st), 8'(nav_link_pkg::LINK_DETECTING));
    chk({7'h0, disp.no_comm_msg}, 8'h01);
    for (int i = 0; i < 24 && st !== nav_link_pkg::LINK_LOCKED; i++)
      gps_nav_model_i.send_char(DIV_M, nmea[i % 8]);
    tick(5);
    chk(8'(st), 8'(nav_link_pkg::LINK_LOCKED));
    chk(8'(fmt), 8'(nav_link_pkg::NAV_MARINE));
    chk({7'h0, tx_ready}, 8'h00);
    fork
      gps_nav_model_i.send_char(DIV_M, 8'h47);
      begin
        n = 0;
        while (nav_valid !== 1'b1 && n < 5000)
        begin
          tick(1);
          n++;
        end
        expire(n, 5000);
        chk(nav_data, 8'h47);
      end
    join
    for (int i = 0; i < 4; i++)
    begin
      {nsig, nwpt} = 2'(i);
      tick(3);
      chk(8'(disp), {3'h0, nsig, ~nsig & nwpt, {2{~nsig & ~nwpt}}, ~nsig});
    end
    {nsig, nwpt} = 2'h0;
    wait_leave(nav_link_pkg::LINK_LOCKED);
    chk(8'(st), 8'(nav_link_pkg::LINK_RESTART));
    wait_leave(nav_link_pkg::LINK_RESTART);
    tick(2);
    chk(8'(st), 8'(nav_link_pkg::LINK_SILENT));
    chk({5'h0, disp[2:0]}, 8'h00);
    complete_run();
  end
endmodule
